//--- core/tseg_pkg.sv
// Package: register map, field positions and reset values of the software event block
package tseg_pkg;
    localparam logic [7:0]  ADDR_INTF    = 8'h10;
    localparam logic [7:0]  ADDR_SWEVG   = 8'h14;
    localparam logic [7:0]  ADDR_CTRL    = 8'h20;
    localparam logic [7:0]  ADDR_DIER    = 8'h24;
    localparam logic [7:0]  ADDR_CNT     = 8'h28;
    localparam logic [7:0]  ADDR_CAR     = 8'h2C;
    localparam logic [7:0]  ADDR_CV0     = 8'h34;
    localparam logic [7:0]  ADDR_SHAD    = 8'h44;
    localparam logic [7:0]  ADDR_OUTCTL  = 8'h48;
    localparam int          BIT_UPG      = 0;
    localparam int          BIT_CHAN0_EVENT_REQUEST     = 1;
    localparam int          BIT_COMMUTATION_REQUEST_BIT     = 5;
    localparam int          BIT_TRIGGER_REQUEST_BIT     = 6;
    localparam int          BIT_BREAK_REQUEST_BIT     = 7;
    localparam int          BIT_OF0      = 9;
    localparam int          CTRL_DIR     = 0;
    localparam int          CTRL_CAM0    = 1;
    localparam int          CTRL_COMMUTATION_SHADOW_SELECT    = 3;
    localparam int          CTRL_PRIMARY_OUTPUT_ENABLE    = 4;
    localparam int          CTRL_IN0     = 8;
    localparam logic [15:0] RST_CTRL     = 16'h0000;
    localparam logic [15:0] RST_FLAGS    = 16'h0000;
    localparam logic [15:0] FLAG_MASK    = 16'h1EFF;
    localparam logic [15:0] SWEVG_MASK   = 16'h00FF;
endpackage

//--- core/tseg_chan.sv
// Single capture/compare channel: software event flag, capture and over-capture
`timescale 1ns/1ns
module tseg_chan #(
    parameter int W = 16
) (
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic         ce,
    input  wire logic         ev,
    input  wire logic         in_mode,
    input  wire logic         clr_if,
    input  wire logic         clr_of,
    input  wire logic         wr_cv,
    input  wire logic [W-1:0] wdata,
    input  wire logic [W-1:0] cnt,
    output logic              if_q,
    output logic              of_q,
    output logic [W-1:0]      cv_q
);
    if (W < 1) begin : gen_bad_width
        $error("tseg_chan: unsupported width");
    end

    logic         if_d;
    logic         of_d;
    logic [W-1:0] cv_d;

    always_comb begin
        if_d = if_q;
        of_d = of_q;
        cv_d = cv_q;
        if (clr_if) begin
            if_d = 1'b0;
        end
        if (clr_of) begin
            of_d = 1'b0;
        end
        if (wr_cv && !in_mode) begin
            cv_d = wdata;
        end
        // Set wins over a clear in the same cycle
        if (ev) begin
            if_d = 1'b1;
            if (in_mode) begin
                cv_d = cnt;
                if (if_q) begin
                    of_d = 1'b1;
                end
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            if_q <= 1'b0;
            of_q <= 1'b0;
            cv_q <= '0;
        end else if (ce) begin
            if_q <= if_d;
            of_q <= of_d;
            cv_q <= cv_d;
        end
    end

    a_over_capture: assert property (@(posedge clk) disable iff (!rst_n)
        ce && ev && in_mode && if_q |=> of_q)
        else $error("over-capture flag not set");
    a_capture_value: assert property (@(posedge clk) disable iff (!rst_n)
        ce && ev && in_mode |=> cv_q == $past(cnt))
        else $error("capture value wrong");
endmodule

//--- core/tseg_top.sv
// Software event generation for an advanced timer, APB register slave
//
// Decided for this implementation: the address map and the APB slave port.
`timescale 1ns/1ns
module tseg_top #(
    parameter int CNT_W = 16,
    parameter int PSC_W = 16
) (
    input  wire logic        CORE_CLK,
    input  wire logic        RESET_N,
    input  wire logic        CLK_EN,
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [7:0]  PADDR,
    input  wire logic [31:0] PWDATA,
    input  wire logic [3:0]  PSTRB,
    output logic             PREADY,
    output logic [31:0]      PRDATA,
    output logic             PSLVERR,
    output logic             IRQ,
    output logic             DMA_REQ,
    output logic             PRIMARY_OUTPUT_ENABLE,
    output logic [11:0]      CHAN_OUTPUT_CTL
);
    if (CNT_W != 16 || PSC_W < 1 || PSC_W > 16) begin : gen_bad_width
        $error("tseg_top: unsupported width");
    end

    //------------------------------------------------------------
    // Bus decode
    //------------------------------------------------------------
    logic acc;
    logic wr;
    logic [15:0] wd;
    logic lo_en;
    assign acc   = PSEL && PENABLE;
    assign wr    = acc && PWRITE;
    assign lo_en = PSTRB[0] || PSTRB[1];
    // Half-word and word writes both land in the low lanes
    assign wd    = {PSTRB[1] ? PWDATA[15:8] : 8'h00, PSTRB[0] ? PWDATA[7:0] : 8'h00};

    logic hit_swevg;
    assign hit_swevg = wr && lo_en && PADDR == tseg_pkg::ADDR_SWEVG;

    //------------------------------------------------------------
    // Request pulses
    //------------------------------------------------------------
    logic [7:0] req_q;
    logic [7:0] req_d;
    always_comb begin
        // Upper reserved bits are dropped
        req_d = hit_swevg ? (wd[7:0] & tseg_pkg::SWEVG_MASK[7:0]) : 8'h00;
    end

    logic [15:0] ctrl_q;
    logic [15:0] ctrl_d;
    logic [15:0] dier_q;
    logic [15:0] dier_d;
    logic [15:0] cnt_q;
    logic [15:0] cnt_d;
    logic [15:0] car_q;
    logic [15:0] car_d;
    logic [PSC_W-1:0] psc_q;
    logic [PSC_W-1:0] psc_d;
    logic [11:0] shad_q;
    logic [11:0] shad_d;
    logic [11:0] outc_q;
    logic [11:0] outc_d;
    logic [15:0] flag_q;
    logic [15:0] flag_d;
    logic        primary_output_enable_q;
    logic        primary_output_enable_d;
    logic [3:0]  ch_if;
    logic [3:0]  ch_of;
    logic [15:0] ch_cv [4];
    logic [3:0]  clr_if;
    logic [3:0]  clr_of;
    logic [3:0]  wr_cv;

    //------------------------------------------------------------
    // Channels
    //------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : gen_ch
            assign clr_if[g] = wr && lo_en && PADDR == tseg_pkg::ADDR_INTF && !wd[g+1];
            assign clr_of[g] = wr && lo_en && PADDR == tseg_pkg::ADDR_INTF
                               && !wd[tseg_pkg::BIT_OF0+g];
            assign wr_cv[g]  = wr && lo_en && PADDR == tseg_pkg::ADDR_CV0 + 8'(4*g);
            tseg_chan #(.W(16)) u_chan (
                .clk     (CORE_CLK),
                .rst_n   (RESET_N),
                .ce      (CLK_EN),
                .ev      (req_q[tseg_pkg::BIT_CHAN0_EVENT_REQUEST+g]),
                .in_mode (ctrl_q[tseg_pkg::CTRL_IN0+g]),
                .clr_if  (clr_if[g]),
                .clr_of  (clr_of[g]),
                .wr_cv   (wr_cv[g]),
                .wdata   (wd),
                .cnt     (cnt_q),
                .if_q    (ch_if[g]),
                .of_q    (ch_of[g]),
                .cv_q    (ch_cv[g])
            );
        end
    endgenerate

    //------------------------------------------------------------
    // Control, counter and flags
    //------------------------------------------------------------
    logic [15:0] cnt_tick;
    logic        cnt_down;
    assign cnt_down = ctrl_q[tseg_pkg::CTRL_DIR] && ctrl_q[2:1] == 2'h0;
    assign cnt_tick = cnt_down ? cnt_q - 16'h0001 : cnt_q + 16'h0001;

    always_comb begin
        ctrl_d = ctrl_q;
        dier_d = dier_q;
        car_d  = car_q;
        shad_d = shad_q;
        outc_d = outc_q;
        cnt_d  = cnt_tick;
        psc_d  = psc_q + PSC_W'(1);
        flag_d = flag_q;
        primary_output_enable_d = primary_output_enable_q;
        if (wr && lo_en) begin
            case (PADDR)
                tseg_pkg::ADDR_CTRL: ctrl_d = wd;
                tseg_pkg::ADDR_DIER: dier_d = wd;
                tseg_pkg::ADDR_CAR:  car_d  = wd;
                tseg_pkg::ADDR_CNT:  cnt_d  = wd;
                tseg_pkg::ADDR_SHAD: shad_d = wd[11:0];
                tseg_pkg::ADDR_INTF: flag_d = flag_q & wd;
                default: ;
            endcase
        end
        primary_output_enable_d = ctrl_d[tseg_pkg::CTRL_PRIMARY_OUTPUT_ENABLE] ? 1'b1 : primary_output_enable_q;
        if (wr && lo_en && PADDR == tseg_pkg::ADDR_CTRL) begin
            primary_output_enable_d = wd[tseg_pkg::CTRL_PRIMARY_OUTPUT_ENABLE];
        end
        ctrl_d[tseg_pkg::CTRL_PRIMARY_OUTPUT_ENABLE] = 1'b0;
        if (req_q[tseg_pkg::BIT_BREAK_REQUEST_BIT]) begin
            primary_output_enable_d = 1'b0;
            flag_d[tseg_pkg::BIT_BREAK_REQUEST_BIT] = 1'b1;
        end
        if (req_q[tseg_pkg::BIT_TRIGGER_REQUEST_BIT]) begin
            flag_d[tseg_pkg::BIT_TRIGGER_REQUEST_BIT] = 1'b1;
        end
        if (req_q[tseg_pkg::BIT_COMMUTATION_REQUEST_BIT]) begin
            // Shadow select bit is not used anywhere; software request always loads
            outc_d = shad_q;
            flag_d[tseg_pkg::BIT_COMMUTATION_REQUEST_BIT] = 1'b1;
        end
        if (req_q[tseg_pkg::BIT_UPG]) begin
            cnt_d  = cnt_down ? car_q : 16'h0000;
            psc_d  = '0;
            flag_d[tseg_pkg::BIT_UPG] = 1'b1;
        end
        flag_d = flag_d & tseg_pkg::FLAG_MASK;
        flag_d[4:1] = 4'h0;
        flag_d[12:9] = 4'h0;
    end

    logic [15:0] flags_all;
    assign flags_all = flag_q | {3'h0, ch_of, 4'h0, ch_if, 1'b0};

    logic [15:0] ctrl_rd;
    assign ctrl_rd = ctrl_q | (16'(primary_output_enable_q) << tseg_pkg::CTRL_PRIMARY_OUTPUT_ENABLE);

    logic [31:0] rd;
    always_comb begin
        case (PADDR)
            tseg_pkg::ADDR_INTF:       rd = {16'h0000, flags_all};
            tseg_pkg::ADDR_SWEVG:      rd = 32'h0000_0000;
            tseg_pkg::ADDR_CTRL:       rd = {16'h0000, ctrl_rd};
            tseg_pkg::ADDR_DIER:       rd = {16'h0000, dier_q};
            tseg_pkg::ADDR_CNT:        rd = {16'h0000, cnt_q};
            tseg_pkg::ADDR_CAR:        rd = {16'h0000, car_q};
            tseg_pkg::ADDR_CV0:        rd = {16'h0000, ch_cv[0]};
            tseg_pkg::ADDR_CV0 + 8'h4: rd = {16'h0000, ch_cv[1]};
            tseg_pkg::ADDR_CV0 + 8'h8: rd = {16'h0000, ch_cv[2]};
            tseg_pkg::ADDR_CV0 + 8'hC: rd = {16'h0000, ch_cv[3]};
            tseg_pkg::ADDR_SHAD:       rd = {20'h00000, shad_q};
            tseg_pkg::ADDR_OUTCTL:     rd = {20'h00000, outc_q};
            default:                   rd = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge CORE_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            req_q   <= 8'h00;
            ctrl_q  <= tseg_pkg::RST_CTRL;
            dier_q  <= 16'h0000;
            cnt_q   <= 16'h0000;
            car_q   <= 16'hFFFF;
            psc_q   <= '0;
            shad_q  <= 12'h000;
            outc_q  <= 12'h000;
            flag_q  <= tseg_pkg::RST_FLAGS;
            primary_output_enable_q  <= 1'b0;
            PREADY  <= 1'b0;
            PRDATA  <= 32'h0000_0000;
            PSLVERR <= 1'b0;
            IRQ     <= 1'b0;
            DMA_REQ <= 1'b0;
            PRIMARY_OUTPUT_ENABLE <= 1'b0;
            CHAN_OUTPUT_CTL       <= 12'h000;
        end else if (CLK_EN) begin
            req_q   <= req_d;
            ctrl_q  <= ctrl_d;
            dier_q  <= dier_d;
            cnt_q   <= cnt_d;
            car_q   <= car_d;
            psc_q   <= psc_d;
            shad_q  <= shad_d;
            outc_q  <= outc_d;
            flag_q  <= flag_d;
            primary_output_enable_q  <= primary_output_enable_d;
            PREADY  <= PSEL && !PENABLE;
            PRDATA  <= rd;
            PSLVERR <= 1'b0;
            IRQ     <= |(flags_all[7:0] & dier_q[7:0]);
            DMA_REQ <= |(flags_all[7:0] & dier_q[15:8]);
            PRIMARY_OUTPUT_ENABLE <= primary_output_enable_q;
            CHAN_OUTPUT_CTL       <= outc_q;
        end
    end

    //------------------------------------------------------------
    // Checks
    //------------------------------------------------------------
    a_break_flag: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
        CLK_EN && req_q[7] |=> flag_q[7] && !primary_output_enable_q)
        else $error("break request not applied");
    a_break_output: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
        CLK_EN && req_q[7] ##1 CLK_EN |=> !PRIMARY_OUTPUT_ENABLE)
        else $error("output enable still high after break");
    a_trig_flag: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
        CLK_EN && req_q[6] |=> flag_q[6])
        else $error("trigger flag not set");
    a_trig_irq: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
        CLK_EN && req_q[6] && dier_q[6] ##1 CLK_EN |=> IRQ)
        else $error("trigger interrupt not raised");
    a_commut_load: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
        CLK_EN && req_q[5] |=> outc_q == $past(shad_q))
        else $error("commutation load missing");
    a_outctl_copy: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
        CLK_EN |=> CHAN_OUTPUT_CTL == $past(outc_q))
        else $error("channel output control not forwarded");
    a_upd_counter: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
        CLK_EN && req_q[0] && !cnt_down |=> cnt_q == 16'h0000 && psc_q == '0)
        else $error("update did not clear counter");
    a_upd_reload: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
        CLK_EN && req_q[0] && cnt_down |=> cnt_q == $past(car_q))
        else $error("update did not reload counter");
    a_upd_prescaler: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
        CLK_EN && req_q[0] |=> psc_q == '0)
        else $error("update did not clear prescaler");
    a_upd_flag: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
        CLK_EN && req_q[0] |=> flag_q[0])
        else $error("update flag not set");
    a_req_pulse: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
        CLK_EN && hit_swevg && wd[7:0] != 8'h00 ##1 CLK_EN
            |-> req_q != 8'h00 ##1 req_q == 8'h00)
        else $error("request not single pulse");
    // Half-word and word writes must request the same bits
    a_req_capture: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
        CLK_EN && hit_swevg && PSTRB[0] |=> req_q == 8'($past(PWDATA)))
        else $error("request bits not taken from write data");
    a_swevg_read: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
        CLK_EN && PSEL && !PENABLE && PADDR == tseg_pkg::ADDR_SWEVG |=> PRDATA == 32'h0000_0000)
        else $error("event register read not zero");
    a_chan_flag: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
        CLK_EN && |req_q[4:1] |=> (ch_if & $past(req_q[4:1])) == $past(req_q[4:1]))
        else $error("channel flag not set");
    a_ready_setup: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
        CLK_EN && PSEL && !PENABLE |=> PREADY)
        else $error("ready missing after setup");
    // Counter, flags and PREADY stand in for every group held by the enable
    a_clk_freeze: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
        !CLK_EN |=> $stable(cnt_q) && $stable(flag_q) && $stable(PREADY))
        else $error("state moved while clock enable low");

    //------------------------------------------------------------
    // Cover points
    //------------------------------------------------------------
    c_break: cover property (@(posedge CORE_CLK) req_q[7]);
    c_commut: cover property (@(posedge CORE_CLK) req_q[5]);
    c_capture: cover property (@(posedge CORE_CLK) |(req_q[4:1] & ctrl_q[11:8]));
    c_update_down: cover property (@(posedge CORE_CLK) req_q[0] && cnt_down);
    c_over_cap: cover property (@(posedge CORE_CLK) |ch_of);
endmodule

//--- verif/tseg_top_test.sv
// Self-checking bench for the software event block over APB
`timescale 1ns/1ns
module tseg_top_test;
    logic        clk;
    logic        rst_n;
    logic        clk_en;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [3:0]  pstrb;
    logic        pready;
    logic [31:0] prdata;
    logic        pslverr;
    logic        irq;
    logic        dma_req;
    logic        primary_output_enable;
    logic [11:0] out_ctl;
    logic [31:0] rv;
    logic [15:0] x;
    logic [11:0] s;
    logic        e;
    logic [15:0] modes [4] = '{16'h0000, 16'h0001, 16'h0002, 16'h0007};
    int          failures = 0;
    int          checks = 0;
    int          cycles = 0;

    tseg_top u_dut (
        .CORE_CLK              (clk),
        .RESET_N               (rst_n),
        .CLK_EN                (clk_en),
        .PSEL                  (psel),
        .PENABLE               (penable),
        .PWRITE                (pwrite),
        .PADDR                 (paddr),
        .PWDATA                (pwdata),
        .PSTRB                 (pstrb),
        .PREADY                (pready),
        .PRDATA                (prdata),
        .PSLVERR               (pslverr),
        .IRQ                   (irq),
        .DMA_REQ               (dma_req),
        .PRIMARY_OUTPUT_ENABLE (primary_output_enable),
        .CHAN_OUTPUT_CTL       (out_ctl)
    );

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    // ----------------------------------------
    // Bus and check tasks
    // ----------------------------------------
    task automatic wrap_up;
        if (failures == 0 && checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // Cut a hang short; whole run needs well under a thousand cycles
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            failures++;
            wrap_up();
        end
    end

    // Idle edge first, so back-to-back calls never drive a signal twice at once
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       input logic [3:0] st, output logic [31:0] r);
        @(posedge clk);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        pstrb  <= st;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        r = prdata;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        logic [31:0] r;
        apb(1'b1, a, {16'h0000, d}, ($urandom % 2) ? 4'hF : 4'h3, r);
    endtask

    task automatic rd(input logic [7:0] a);
        apb(1'b0, a, 32'h0000_0000, 4'h0, rv);
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            failures++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask

    // Free-running counter: exact landing cycle left to the design
    task automatic chk_rng(input logic [31:0] got, input logic [31:0] lo, input int n);
        checks++;
        if ($isunknown(got) || (got - lo) >= n) begin
            failures++;
            $display("BAD %0t value %h outside window from %h", $time, got, lo);
        end
    endtask

    function automatic logic [31:0] flag_of(input int b, input bit over);
        flag_of = (32'h1 << b) | (over ? (32'h100 << b) : 32'h0);
    endfunction

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        rst_n = 1'b0;
        clk_en = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        pstrb = 4'h0;
        void'($urandom(17625));
        repeat (5) @(posedge clk);
        chk({17'h0, primary_output_enable, irq, dma_req, out_ctl}, 32'h0);
        rst_n  <= 1'b1;
        clk_en <= 1'b1;
        rd(tseg_pkg::ADDR_INTF);
        chk(rv, 32'h0);
        wr(tseg_pkg::ADDR_CTRL, 16'h0010);
        s = 12'($urandom);
        wr(tseg_pkg::ADDR_SHAD, {4'h0, s});
        chk({31'h0, primary_output_enable}, 32'h1);
        // Every request bit but update, routed to irq or dma at random
        for (int b = 1; b < 8; b++) begin
            e = 1'($urandom % 2);
            wr(tseg_pkg::ADDR_INTF, 16'h0000);
            wr(tseg_pkg::ADDR_DIER, e ? (16'h0100 << b) : (16'h0001 << b));
            wr(tseg_pkg::ADDR_SWEVG, 16'h0001 << b);
            rd(tseg_pkg::ADDR_SWEVG);
            chk(rv, 32'h0);
            rd(tseg_pkg::ADDR_INTF);
            chk(rv, flag_of(b, 1'b0));
            chk({30'h0, irq, dma_req}, e ? 32'h1 : 32'h2);
        end
        chk({31'h0, primary_output_enable}, 32'h0);
        chk({20'h0, out_ctl}, {20'h0, s});
        // Captures in input mode, second one overruns the flag
        wr(tseg_pkg::ADDR_CTRL, 16'h0F00);
        for (int k = 0; k < 4; k++) begin
            x = 16'($urandom % 16'h4000) + 16'h0100;
            wr(tseg_pkg::ADDR_INTF, 16'h0000);
            wr(tseg_pkg::ADDR_CNT, x);
            wr(tseg_pkg::ADDR_SWEVG, 16'h0002 << k);
            rd(tseg_pkg::ADDR_CV0 + 8'(4 * k));
            chk_rng(rv, {16'h0, x}, 8);
            wr(tseg_pkg::ADDR_SWEVG, 16'h0002 << k);
            rd(tseg_pkg::ADDR_INTF);
            chk(rv, flag_of(k + 1, 1'b1));
        end
        // Update in up, down and centre modes; direction bit ignored in centre
        for (int m = 0; m < 4; m++) begin
            x = 16'($urandom % 16'h4000) + 16'h1000;
            wr(tseg_pkg::ADDR_CAR, x);
            wr(tseg_pkg::ADDR_CTRL, modes[m]);
            wr(tseg_pkg::ADDR_CNT, x - 16'h0800);
            wr(tseg_pkg::ADDR_INTF, 16'h0000);
            wr(tseg_pkg::ADDR_SWEVG, 16'h0001);
            rd(tseg_pkg::ADDR_CNT);
            if (m == 1)
                chk_rng({16'h0, x} - rv, 32'h0, 8);
            else
                chk_rng(rv, 32'h0, 8);
            rd(tseg_pkg::ADDR_INTF);
            chk(rv, 32'h1);
        end
        wr(tseg_pkg::ADDR_INTF, 16'hFFFF);
        rd(tseg_pkg::ADDR_INTF);
        chk(rv, 32'h1);
        // Enable low for a random gap: counter must not move
        x = 16'($urandom % 16'h4000) + 16'h0100;
        wr(tseg_pkg::ADDR_CNT, x);
        clk_en <= 1'b0;
        repeat (10 + $urandom % 20) @(posedge clk);
        clk_en <= 1'b1;
        rd(tseg_pkg::ADDR_CNT);
        chk_rng(rv, {16'h0, x}, 4);
        // A refused write, an empty request and an unmapped place
        wr(tseg_pkg::ADDR_INTF, 16'h0000);
        apb(1'b1, tseg_pkg::ADDR_SWEVG, 32'h0000_0040, 4'h0, rv);
        wr(tseg_pkg::ADDR_SWEVG, 16'h0000);
        rd(tseg_pkg::ADDR_INTF);
        chk(rv, 32'h0);
        rd(8'hFC);
        chk(rv, 32'h0);
        chk({31'h0, pslverr}, 32'h0);
        wrap_up();
    end
endmodule
